// ---- smr_assertions.sv ----
`timescale 1ns/1ns
// ============================================================
// bus checks across both ends of the link
module smr_assertions (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // ==========================================================
  // assertions
  // lines float high at the first edge out of reset
  reset_idle_a: assert property (
    !$past(resetn) |-> !host_scl_oe && !host_sda_oe && !dev_sda_oe)
    else $error("bus driven right after reset");
  // device moves sda only while scl is low
  dev_edge_a: assert property (
    $changed(dev_sda_oe) |-> !scl)
    else $error("device changed sda with scl high");
  // driven bit holds for at least eight clocks
  dev_hold_a: assert property (
    $rose(dev_sda_oe) |-> dev_sda_oe [*8])
    else $error("device bit dropped too soon");
  // setup margin: drive lands early in the low phase
  dev_setup_a: assert property (
    $rose(dev_sda_oe) |-> !scl [*8])
    else $error("device drove sda late");
  // the bit is clocked out within 80 clocks, five quarter periods
  dev_bound_a: assert property (
    $rose(dev_sda_oe) |-> ##[1:80] $fell(scl))
    else $error("no scl fall after device bit");
  // open drain: never two drivers while scl is high
  no_fight_a: assert property (
    scl && dev_sda_oe |-> !host_sda_oe)
    else $error("host and device both drive sda");
  // clock low and high phases are never glitches
  scl_low_a: assert property (
    $rose(host_scl_oe) |-> host_scl_oe [*8])
    else $error("scl low phase too short");
  scl_high_a: assert property (
    $fell(host_scl_oe) |-> !host_scl_oe [*8])
    else $error("scl high phase too short");

  // ==========================================================
  // covers: start, stop, device drive
  cover property (scl && $fell(sda));
  cover property (scl && $rose(sda));
  cover property ($rose(dev_sda_oe));
endmodule

// ---- smr_bus_if.sv ----
`timescale 1ns/1ns
// ============================================================
// two-wire bus: open-drain lines with pull-up resolution
interface smr_bus_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // an enabled driver wins, otherwise the pull-up holds high
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1)
             & (dev_sda_oe  ? dev_sda_o  : 1'b1);

  modport dev (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe
  );

  modport host (
    input  scl,
    input  sda,
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe
  );
endinterface

// ---- smr_dev.sv ----
`timescale 1ns/1ns
// Overview of operation
// - no ack to memory address while writing
// - host polls with memory address only; smr_host polls with the register id when ccr_r is set
// - stop after memory data starts write cycle
// - counter holds last read address plus one
// - counter clears to zero at reset
// - ack read address, send counter byte
// - host ends read with nack, stop
// - random read: dummy write, restart, read
// - ack address bytes, then return data
// - stop after address loads counter
// - after stop, ignore bus until start
// - each host ack sends next byte
// - counter crosses page boundaries freely
// - counter wraps at end of space
// - six-bit load capacitance trim setting
// - three-bit pulse add/skip trim
// - decode target id and select bits
// - release line, stop sending on nack
module smr_dev #(
  parameter int WR_CYCLES = smr_pkg::WR_CYC
) (
  input  wire logic  mclk,
  input  wire logic  resetn,
  smr_bus_if.dev     bus,
  output logic [5:0] load_cap_trim,
  output logic [2:0] freq_trim,
  output logic       wr_busy
);

  localparam int CW = $clog2(WR_CYCLES + 1);

  // ==========================================================
  // state
  smr_pkg::smr_dst_e st_r, st_nxt;
  logic [2:0]  scl_sy_r, scl_sy_nxt;
  logic [2:0]  sda_sy_r, sda_sy_nxt;
  logic [3:0]  bitc_r, bitc_nxt;
  logic [7:0]  sh_r, sh_nxt;
  logic [1:0]  bidx_r, bidx_nxt;
  logic        ccr_r, ccr_nxt;
  logic        rd_r, rd_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic        oe_r, oe_nxt;
  logic        mack_r, mack_nxt;
  logic        seen_r, seen_nxt;
  logic [5:0]  lct_r, lct_nxt;
  logic [2:0]  ftr_r, ftr_nxt;
  logic [CW-1:0] wcnt_r, wcnt_nxt;
  logic        busy_r, busy_nxt;
  logic [7:0]  mem_r [2**smr_pkg::MEM_AW];
  logic [7:0]  mem_nxt [2**smr_pkg::MEM_AW];
  logic        rise, fall, start_c, stop_c, ack_c;
  logic [7:0]  rbyte;

  // next address; the full 16-bit space rolls over to zero
  function automatic logic [15:0] inc_addr(input logic [15:0] a);
    return 16'(a + 16'h0001);
  endfunction

  // trim values read back through the register target
  function automatic logic [7:0] ccr_read(input logic [15:0] a,
                                          input logic [5:0]  l,
                                          input logic [2:0]  f);
    if (a == smr_pkg::CCR_LCT) begin
      return {2'h0, l};
    end else if (a == smr_pkg::CCR_FTR) begin
      return {5'h00, f};
    end else begin
      return 8'h00;
    end
  endfunction

  // ==========================================================
  // byte to send at the current counter
  // only the low counter bits are backed; higher ones alias
  assign rbyte = ccr_r ? ccr_read(addr_r, lct_r, ftr_r)
                       : mem_r[addr_r[smr_pkg::MEM_AW-1:0]];

  // line events from the second and delayed copies only
  assign rise    = scl_sy_r[1] & ~scl_sy_r[2];
  assign fall    = ~scl_sy_r[1] & scl_sy_r[2];
  assign start_c = scl_sy_r[1] & scl_sy_r[2] & sda_sy_r[2] & ~sda_sy_r[1];
  assign stop_c  = scl_sy_r[1] & scl_sy_r[2] & ~sda_sy_r[2] & sda_sy_r[1];

  // ==========================================================
  // protocol engine next values
  always_comb begin
    st_nxt     = st_r;
    bitc_nxt   = bitc_r;
    sh_nxt     = sh_r;
    bidx_nxt   = bidx_r;
    ccr_nxt    = ccr_r;
    rd_nxt     = rd_r;
    addr_nxt   = addr_r;
    oe_nxt     = oe_r;
    mack_nxt   = mack_r;
    seen_nxt   = seen_r;
    lct_nxt    = lct_r;
    ftr_nxt    = ftr_r;
    mem_nxt    = mem_r;
    ack_c      = 1'b0;
    scl_sy_nxt = {scl_sy_r[1:0], bus.scl}; // bit 0 only feeds bit 1
    sda_sy_nxt = {sda_sy_r[1:0], bus.sda};
    wcnt_nxt   = (wcnt_r != '0) ? CW'(wcnt_r - 1'b1) : wcnt_r;
    if (start_c) begin
      st_nxt   = smr_pkg::D_RECV;
      bitc_nxt = 4'h0;
      bidx_nxt = 2'h0;
      oe_nxt   = 1'b0;
      seen_nxt = 1'b0;
    end else if (stop_c) begin
      st_nxt   = smr_pkg::D_IDLE;
      oe_nxt   = 1'b0;
      seen_nxt = 1'b0;
      if (seen_r && !ccr_r) begin
        wcnt_nxt = CW'(WR_CYCLES);
      end
    end else begin
      case (st_r)
        smr_pkg::D_RECV: begin
          if (rise) begin
            sh_nxt   = {sh_r[6:0], sda_sy_r[1]};
            bitc_nxt = 4'(bitc_r + 4'h1);
          end else if (fall && bitc_r == 4'h8) begin
            if (bidx_r == 2'h0) begin
              ack_c = (sh_r[7:4] == smr_pkg::ID_MEM
                       || sh_r[7:4] == smr_pkg::ID_CCR)
                      && sh_r[3:1] == smr_pkg::DEV_SEL
                      && wcnt_r == '0;
              ccr_nxt = (sh_r[7:4] == smr_pkg::ID_CCR);
              rd_nxt  = sh_r[0];
            end else if (bidx_r == 2'h1) begin
              addr_nxt[15:8] = sh_r;
              ack_c          = 1'b1;
            end else if (bidx_r == 2'h2) begin
              addr_nxt[7:0] = sh_r;
              ack_c         = 1'b1;
            end else begin
              // data byte of a write
              if (ccr_r) begin
                if (addr_r == smr_pkg::CCR_LCT) begin
                  lct_nxt = sh_r[5:0];
                end
                if (addr_r == smr_pkg::CCR_FTR) begin
                  ftr_nxt = sh_r[2:0];
                end
              end else begin
                mem_nxt[addr_r[smr_pkg::MEM_AW-1:0]] = sh_r;
              end
              addr_nxt = inc_addr(addr_r);
              seen_nxt = 1'b1;
              ack_c    = 1'b1;
            end
            if (bidx_r != 2'h3) begin
              bidx_nxt = 2'(bidx_r + 2'h1);
            end
            oe_nxt = ack_c;
            st_nxt = ack_c ? smr_pkg::D_ACK : smr_pkg::D_IDLE;
          end
        end
        smr_pkg::D_ACK: begin
          if (fall) begin
            bitc_nxt = 4'h0;
            if (rd_r) begin
              sh_nxt = rbyte;
              oe_nxt = ~rbyte[7];
              st_nxt = smr_pkg::D_SEND;
            end else begin
              oe_nxt = 1'b0;
              st_nxt = smr_pkg::D_RECV;
            end
          end
        end
        smr_pkg::D_SEND: begin
          if (fall) begin
            if (bitc_r == 4'h7) begin
              oe_nxt = 1'b0;
              st_nxt = smr_pkg::D_MACK;
              addr_nxt = inc_addr(addr_r);
            end else begin
              sh_nxt   = {sh_r[6:0], 1'b0};
              oe_nxt   = ~sh_r[6];
              bitc_nxt = 4'(bitc_r + 4'h1);
            end
          end
        end
        smr_pkg::D_MACK: begin
          if (rise) begin
            mack_nxt = ~sda_sy_r[1];
          end else if (fall) begin
            if (mack_r) begin
              sh_nxt   = rbyte;
              oe_nxt   = ~rbyte[7];
              bitc_nxt = 4'h0;
              st_nxt   = smr_pkg::D_SEND;
            end else begin
              st_nxt = smr_pkg::D_IDLE;
            end
          end
        end
        default: begin
          st_nxt = smr_pkg::D_IDLE;
        end
      endcase
    end
    busy_nxt = (wcnt_nxt != '0);
  end

  // ==========================================================
  // registers; storage contents are not cleared by reset
  always_ff @(posedge mclk) begin
    mem_r <= mem_nxt;
    if (!resetn) begin
      st_r     <= smr_pkg::D_IDLE;
      scl_sy_r <= 3'h7;
      sda_sy_r <= 3'h7;
      bitc_r   <= 4'h0;
      sh_r     <= 8'h00;
      bidx_r   <= 2'h0;
      ccr_r    <= 1'b0;
      rd_r     <= 1'b0;
      addr_r   <= smr_pkg::ADDR_RST;
      oe_r     <= 1'b0;
      mack_r   <= 1'b0;
      seen_r   <= 1'b0;
      lct_r    <= smr_pkg::LCT_RST;
      ftr_r    <= smr_pkg::FTR_RST;
      wcnt_r   <= '0;
      busy_r   <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      scl_sy_r <= scl_sy_nxt;
      sda_sy_r <= sda_sy_nxt;
      bitc_r   <= bitc_nxt;
      sh_r     <= sh_nxt;
      bidx_r   <= bidx_nxt;
      ccr_r    <= ccr_nxt;
      rd_r     <= rd_nxt;
      addr_r   <= addr_nxt;
      oe_r     <= oe_nxt;
      mack_r   <= mack_nxt;
      seen_r   <= seen_nxt;
      lct_r    <= lct_nxt;
      ftr_r    <= ftr_nxt;
      wcnt_r   <= wcnt_nxt;
      busy_r   <= busy_nxt;
    end
  end

  // open-drain: only ever pulls low
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = oe_r;
  assign load_cap_trim  = lct_r;
  assign freq_trim      = ftr_r;
  assign wr_busy        = busy_r;
endmodule

// ---- smr_host.sv ----
`timescale 1ns/1ns
// ============================================================
// bus master end: runs one command as a whole transaction
module smr_host (
  input  wire logic          mclk,
  input  wire logic          resetn,
  smr_bus_if.host            bus,
  input  wire logic          cmd_valid,
  input  smr_pkg::smr_op_e   cmd_op,
  input  wire logic          cmd_ccr,
  input  wire logic [15:0]   cmd_addr,
  input  wire logic [7:0]    cmd_wdata,
  input  wire logic [7:0]    cmd_len,
  output logic               cmd_ready,
  output logic               rd_valid,
  output logic [7:0]         rd_data,
  output logic               done,
  output logic               done_nack
);

  localparam int QW = $clog2(smr_pkg::QTR_CYC + 1);

  smr_pkg::smr_hst_e st_r, st_nxt;
  smr_pkg::smr_op_e  op_r, op_nxt;
  logic [QW-1:0] q_r, q_nxt;
  logic [1:0]    ph_r, ph_nxt;
  logic [2:0]    idx_r, idx_nxt;
  logic [3:0]    bitc_r, bitc_nxt;
  logic [7:0]    sh_r, sh_nxt, len_r, len_nxt, wd_r, wd_nxt;
  logic [15:0]   addr_r, addr_nxt;
  logic          ccr_r, ccr_nxt, rbit_r, rbit_nxt;
  logic          scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt;
  logic          s1_r, s1_nxt, s2_r, s2_nxt;
  logic          rdv_r, rdv_nxt, dn_r, dn_nxt, nk_r, nk_nxt;
  logic [7:0]    rdd_r, rdd_nxt;
  logic          rdy_r, rdy_nxt;
  logic          tick, adv;
  logic [2:0]    nx;
  logic [3:0]    id;

  // ==========================================================
  // sequencer next values
  always_comb begin
    st_nxt = st_r;  op_nxt = op_r;  ph_nxt = ph_r;  idx_nxt = idx_r;
    bitc_nxt = bitc_r;  sh_nxt = sh_r;  len_nxt = len_r;
    wd_nxt = wd_r;  addr_nxt = addr_r;  ccr_nxt = ccr_r;
    rbit_nxt = rbit_r;  scl_oe_nxt = scl_oe_r;  sda_oe_nxt = sda_oe_r;
    rdd_nxt = rdd_r;  nk_nxt = nk_r;
    rdv_nxt = 1'b0;
    dn_nxt  = 1'b0;
    adv     = 1'b0;
    nx      = idx_r;
    s1_nxt  = bus.sda;
    s2_nxt  = s1_r;
    tick    = (q_r == QW'(smr_pkg::QTR_CYC - 1));
    q_nxt   = (st_r == smr_pkg::H_IDLE || tick) ? '0 : QW'(q_r + 1'b1);
    // polls use the register id when ccr_r is set, else the memory id
    id      = ccr_r ? smr_pkg::ID_CCR : smr_pkg::ID_MEM;
    case (st_r)
      smr_pkg::H_IDLE: begin
        scl_oe_nxt = 1'b0;
        sda_oe_nxt = 1'b0;
        if (cmd_valid) begin
          op_nxt = cmd_op;  ccr_nxt = cmd_ccr;  addr_nxt = cmd_addr;
          wd_nxt = cmd_wdata;  len_nxt = cmd_len;  nk_nxt = 1'b0;
          ph_nxt = 2'h0;  idx_nxt = smr_pkg::SQ_START;
          st_nxt = smr_pkg::H_START;
        end
      end
      smr_pkg::H_START: begin
        if (tick) begin
          ph_nxt = 2'(ph_r + 2'h1);
          if (ph_r == 2'h0) begin
            sda_oe_nxt = 1'b0;
          end else if (ph_r == 2'h1) begin
            scl_oe_nxt = 1'b0;
          end else if (ph_r == 2'h2) begin
            sda_oe_nxt = 1'b1;
          end else begin
            scl_oe_nxt = 1'b1;
            adv = 1'b1;
            nx  = (op_r == smr_pkg::OP_READ) ? smr_pkg::SQ_SLVR
                : (idx_r == smr_pkg::SQ_START) ? smr_pkg::SQ_SLVW
                : smr_pkg::SQ_SLVR;
          end
        end
      end
      smr_pkg::H_BIT: begin
        if (tick) begin
          ph_nxt = 2'(ph_r + 2'h1);
          if (ph_r == 2'h0) begin
            // ninth bit acks all but the last byte read
            if (idx_r == smr_pkg::SQ_READ) begin
              sda_oe_nxt = (bitc_r == 4'h8) && (len_r != 8'h01);
            end else begin
              sda_oe_nxt = (bitc_r != 4'h8) && !sh_r[7];
            end
          end else if (ph_r == 2'h1) begin
            scl_oe_nxt = 1'b0;
          end else if (ph_r == 2'h2) begin
            rbit_nxt = s2_r;
          end else begin
            scl_oe_nxt = 1'b1;
            bitc_nxt   = 4'(bitc_r + 4'h1);
            if (bitc_r != 4'h8) begin
              sh_nxt = {sh_r[6:0], rbit_r};
            end else if (idx_r == smr_pkg::SQ_READ) begin
              rdv_nxt = 1'b1;
              rdd_nxt = sh_r;
              len_nxt = 8'(len_r - 8'h01);
              adv = 1'b1;
              nx  = (len_r == 8'h01) ? smr_pkg::SQ_STOP : smr_pkg::SQ_READ;
            end else begin
              adv = 1'b1;
              if (rbit_r) begin
                nk_nxt = 1'b1;
                nx     = smr_pkg::SQ_STOP;
              end else if (idx_r == smr_pkg::SQ_SLVW) begin
                nx = (op_r == smr_pkg::OP_POLL) ? smr_pkg::SQ_STOP
                                                : smr_pkg::SQ_AHI;
              end else if (idx_r == smr_pkg::SQ_AHI) begin
                nx = smr_pkg::SQ_ALO;
              end else if (idx_r == smr_pkg::SQ_ALO) begin
                nx = (op_r == smr_pkg::OP_SETA) ? smr_pkg::SQ_STOP
                                                : smr_pkg::SQ_MID;
              end else if (idx_r == smr_pkg::SQ_SLVR) begin
                nx = smr_pkg::SQ_READ;
              end else begin
                nx = smr_pkg::SQ_STOP;
              end
            end
          end
        end
      end
      smr_pkg::H_STOP: begin
        if (tick) begin
          ph_nxt = 2'(ph_r + 2'h1);
          if (ph_r == 2'h0) begin
            sda_oe_nxt = 1'b1;
          end else if (ph_r == 2'h1) begin
            scl_oe_nxt = 1'b0;
          end else if (ph_r == 2'h2) begin
            sda_oe_nxt = 1'b0;
          end else begin
            // next command may poll at once
            dn_nxt = 1'b1;
            st_nxt = smr_pkg::H_IDLE;
          end
        end
      end
      default: begin
        st_nxt = smr_pkg::H_IDLE;
      end
    endcase
    // launch the next step of the sequence
    if (adv) begin
      idx_nxt  = nx;
      bitc_nxt = 4'h0;
      ph_nxt   = 2'h0;
      st_nxt   = smr_pkg::H_BIT;
      if (nx == smr_pkg::SQ_STOP) begin
        st_nxt = smr_pkg::H_STOP;
      end else if (nx == smr_pkg::SQ_MID) begin
        // repeated start after the dummy write
        if (op_r == smr_pkg::OP_RAND) begin
          st_nxt = smr_pkg::H_START;
        end else begin
          sh_nxt = wd_r;
        end
      end else if (nx == smr_pkg::SQ_SLVW) begin
        sh_nxt = {id, smr_pkg::DEV_SEL, 1'b0};
      end else if (nx == smr_pkg::SQ_SLVR) begin
        sh_nxt = {id, smr_pkg::DEV_SEL, 1'b1};
      end else if (nx == smr_pkg::SQ_AHI) begin
        sh_nxt = addr_r[15:8];
      end else if (nx == smr_pkg::SQ_ALO) begin
        sh_nxt = addr_r[7:0];
      end
    end
    rdy_nxt = (st_nxt == smr_pkg::H_IDLE);
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_r <= smr_pkg::H_IDLE;  op_r <= smr_pkg::OP_READ;
      q_r <= '0;  ph_r <= 2'h0;  idx_r <= 3'h0;  bitc_r <= 4'h0;
      sh_r <= 8'h00;  len_r <= 8'h00;  wd_r <= 8'h00;
      addr_r <= 16'h0000;  ccr_r <= 1'b0;  rbit_r <= 1'b1;
      scl_oe_r <= 1'b0;  sda_oe_r <= 1'b0;  s1_r <= 1'b1;
      s2_r <= 1'b1;  rdv_r <= 1'b0;  dn_r <= 1'b0;  nk_r <= 1'b0;
      rdd_r <= 8'h00;  rdy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;  op_r <= op_nxt;  q_r <= q_nxt;
      ph_r <= ph_nxt;  idx_r <= idx_nxt;  bitc_r <= bitc_nxt;
      sh_r <= sh_nxt;  len_r <= len_nxt;  wd_r <= wd_nxt;
      addr_r <= addr_nxt;  ccr_r <= ccr_nxt;  rbit_r <= rbit_nxt;
      scl_oe_r <= scl_oe_nxt;  sda_oe_r <= sda_oe_nxt;
      s1_r <= s1_nxt;  s2_r <= s2_nxt;  rdv_r <= rdv_nxt;
      dn_r <= dn_nxt;  nk_r <= nk_nxt;  rdd_r <= rdd_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  assign bus.host_scl_o  = 1'b0;
  assign bus.host_scl_oe = scl_oe_r;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_sda_oe = sda_oe_r;
  assign cmd_ready       = rdy_r;
  assign rd_valid        = rdv_r;
  assign rd_data         = rdd_r;
  assign done            = dn_r;
  assign done_nack       = nk_r;

endmodule

// ---- smr_pkg.sv ----
// ============================================================
// shared constants for the serial memory read/poll link
package smr_pkg;

  // ==========================================================
  // timing
  localparam int CLK_NS     = 40;
  localparam int WR_TIME_NS = 5_000_000;
  // typical write cycle, rounded down to whole clocks
  localparam int WR_CYC     = WR_TIME_NS / CLK_NS;
  localparam int QTR_NS     = 625;
  // quarter of a serial clock period, rounded up
  localparam int QTR_CYC    = (QTR_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // slave address fields
  localparam logic [3:0] ID_MEM  = 4'ha;
  localparam logic [3:0] ID_CCR  = 4'hd;
  localparam logic [2:0] DEV_SEL = 3'h7;

  // ==========================================================
  // address counter, storage and trim settings
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam int          MEM_AW   = 4;
  localparam logic [15:0] CCR_LCT  = 16'h0010;
  localparam logic [15:0] CCR_FTR  = 16'h0011;
  localparam logic [5:0]  LCT_RST  = 6'h00;
  localparam logic [2:0]  FTR_RST  = 3'h0;

  // ==========================================================
  // host sequence positions
  localparam logic [2:0] SQ_START = 3'h0;
  localparam logic [2:0] SQ_SLVW  = 3'h1;
  localparam logic [2:0] SQ_AHI   = 3'h2;
  localparam logic [2:0] SQ_ALO   = 3'h3;
  localparam logic [2:0] SQ_MID   = 3'h4;
  localparam logic [2:0] SQ_SLVR  = 3'h5;
  localparam logic [2:0] SQ_READ  = 3'h6;
  localparam logic [2:0] SQ_STOP  = 3'h7;

  typedef enum logic [2:0] {
    OP_READ  = 3'h0,
    OP_RAND  = 3'h1,
    OP_SETA  = 3'h2,
    OP_WRITE = 3'h3,
    OP_POLL  = 3'h4
  } smr_op_e;

  typedef enum logic [4:0] {
    D_IDLE = 5'h01,
    D_RECV = 5'h02,
    D_ACK  = 5'h04,
    D_SEND = 5'h08,
    D_MACK = 5'h10
  } smr_dst_e;

  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_START = 4'h2,
    H_BIT   = 4'h4,
    H_STOP  = 4'h8
  } smr_hst_e;

endpackage

// ---- testbench.sv ----
`timescale 1ns/1ns
// ============================================================
// bench: host and device joined on one bus
module testbench;
  logic             mclk = 1'b0;
  logic             resetn = 1'b0;
  logic             cmd_valid = 1'b0;
  smr_pkg::smr_op_e cmd_op = smr_pkg::OP_READ;
  logic             cmd_ccr = 1'b0;
  logic [15:0]      cmd_addr = 16'h0000;
  logic [7:0]       cmd_wdata = 8'h00;
  logic [7:0]       cmd_len = 8'h01;
  logic             cmd_ready;
  logic             rd_valid;
  logic             done;
  logic             done_nack;
  logic             wr_busy;
  logic [7:0]       rd_data;
  logic [5:0]       load_cap_trim;
  logic [2:0]       freq_trim;
  logic [7:0]       rdq[$];
  int               n_fail = 0;
  int               total_checks = 0;
  int               n_poll;
  logic [15:0]      wa[4] = '{16'h0000, 16'h0001, 16'h0002, 16'h000f};

  // 25 MHz clock
  always #20 mclk = ~mclk;

  // ==========================================================
  // both ends and the checker on one bus
  smr_bus_if bus ();
  // short write cycle keeps polling to a few rounds
  smr_dev #(.WR_CYCLES(2000)) u_smr_dev (
    .mclk(mclk), .resetn(resetn), .bus(bus),
    .load_cap_trim(load_cap_trim), .freq_trim(freq_trim),
    .wr_busy(wr_busy));
  smr_host u_smr_host (
    .mclk(mclk), .resetn(resetn), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_ccr(cmd_ccr), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_len(cmd_len), .cmd_ready(cmd_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .done(done),
    .done_nack(done_nack));
  smr_assertions u_smr_assertions (
    .mclk(mclk), .resetn(resetn), .host_scl_oe(bus.host_scl_oe),
    .host_sda_oe(bus.host_sda_oe), .dev_sda_oe(bus.dev_sda_oe),
    .scl(bus.scl), .sda(bus.sda));

  // read bytes taken mid-cycle, away from the launching edge
  always @(negedge mclk)
    if (rd_valid === 1'b1)
      rdq.push_back(rd_data);

  // ==========================================================
  // tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one whole transaction, returns at the negedge that sees the done pulse high
  task automatic run(input smr_pkg::smr_op_e op, input logic clock_control_regs,
                     input logic [15:0] a, input logic [7:0] d,
                     input logic [7:0] n);
    int k;
    @(negedge mclk);
    while (cmd_ready !== 1'b1)
      @(negedge mclk);
    rdq.delete();
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_ccr <= clock_control_regs;
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_len <= n;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    @(negedge mclk);
    check(16'(cmd_ready), 16'h0000);
    k = 0;
    while (done !== 1'b1 && k < 30000) begin
      @(negedge mclk);
      k++;
    end
    check(16'(k < 30000), 16'h0001);
  endtask

  // memory reads; byte at address x was written as c0 plus x
  task automatic rd(input smr_pkg::smr_op_e op, input logic [15:0] a,
                    input logic [7:0] n, input logic [3:0] ea);
    run(op, 1'b0, a, 8'h00, n);
    check(16'(rdq.size()), 16'(n));
    for (int i = 0; i < n; i++)
      check(16'(rdq[i]), {8'h00, 4'hc, 4'(ea + 4'(i))});
    check(16'(done_nack), 16'h0000);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    // each memory write, then polling until the device answers
    foreach (wa[j]) begin
      run(smr_pkg::OP_WRITE, 1'b0, wa[j], {4'hc, wa[j][3:0]}, 8'h01);
      check(16'(done_nack), 16'h0000);
      check(16'(wr_busy), 16'h0001);
      n_poll = 0;
      do begin
        run(smr_pkg::OP_POLL, 1'b0, 16'h0000, 8'h00, 8'h01);
        n_poll++;
        if (n_poll == 1)
          check(16'(done_nack), 16'h0001);
      end while (done_nack !== 1'b0 && n_poll < 20);
      check(16'(done_nack), 16'h0000);
      check(16'(wr_busy), 16'h0000);
    end
    // trims through the register target, read back in sequence
    run(smr_pkg::OP_WRITE, 1'b1, 16'h0010, 8'h3f, 8'h01);
    run(smr_pkg::OP_WRITE, 1'b1, 16'h0011, 8'h05, 8'h01);
    run(smr_pkg::OP_RAND, 1'b1, 16'h0010, 8'h00, 8'h02);
    check(16'(load_cap_trim), 16'h003f);
    check(16'(freq_trim), 16'h0005);
    check(16'(rdq[0]), 16'h003f);
    check(16'(rdq[1]), 16'h0005);
    // reset between commands: counter and trims clear, memory stays
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    check(16'(load_cap_trim), 16'h0000);
    check(16'(freq_trim), 16'h0000);
    rd(smr_pkg::OP_READ, 16'h0000, 8'h01, 4'h0);
    rd(smr_pkg::OP_READ, 16'h0000, 8'h01, 4'h1);
    run(smr_pkg::OP_SETA, 1'b0, 16'h000f, 8'h00, 8'h01);
    rd(smr_pkg::OP_READ, 16'h0000, 8'h02, 4'hf);
    rd(smr_pkg::OP_RAND, 16'h0201, 8'h01, 4'h1);
    rd(smr_pkg::OP_READ, 16'h0000, 8'h01, 4'h2);
    rd(smr_pkg::OP_RAND, 16'hffff, 8'h03, 4'hf);
    stop_test();
  end

  // hang guard, about twice the expected run length
  initial begin
    repeat (90000) @(posedge mclk);
    n_fail++;
    stop_test();
  end
endmodule
